// ==== verification/i2c_host_model.sv ====
// Host controller model: a bus master that reads the touch controller's status.
// Assumes the bench resolves SDA as open drain with a pull-up and feeds it back.
`timescale 1ns/10ps
module i2c_host_model (
	input wire logic ref_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_rel
);
	// Quarter of a bit in ref_clk cycles; 65 keeps SCL low for 1.3 us, below 400 kHz
	int q = 65;

	initial begin
		scl = 1'h1;
		sda_rel = 1'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic quarter();
		repeat (q) @(posedge ref_clk);
	endtask

	// Start or repeated start: data falls while the clock is high
	task automatic start();
		quarter();
		sda_rel <= 1'h1;
		quarter();
		scl <= 1'h1;
		quarter();
		sda_rel <= 1'h0;
		quarter();
		scl <= 1'h0;
	endtask

	// Stop leaves both lines released, so the clock stands still between frames
	task automatic stop();
		sda_rel <= 1'h0;
		quarter();
		scl <= 1'h1;
		quarter();
		sda_rel <= 1'h1;
		quarter();
	endtask

	// Data set while SCL is low, sampled in the middle of the high phase
	task automatic bit_io(input logic b, output logic r);
		sda_rel <= b;
		quarter();
		scl <= 1'h1;
		quarter();
		r = sda_line;
		quarter();
		scl <= 1'h0;
		quarter();
	endtask

	// Eight bits MSB first, then the acknowledge bit
	task automatic xfer_byte(input logic [7:0] d, input logic ack_out, output logic [7:0] r,
		output logic ack_in);
		for (int n = 7; n >= 0; n--) begin
			bit_io(d[n], r[n]);
		end
		bit_io(ack_out, ack_in);
	endtask
endmodule

// ==== verification/touch_ctrl_tb.sv ====
// Self-checking bench for the touch controller: buttons, slider, fading, host reads.
// Assumes the package constants and a host model that masters the two-wire link.
`timescale 1ns/10ps
module touch_ctrl_tb;
	import touch_pkg::*;
	localparam int FSTEP = 20;
	localparam int SCAN_WAIT = 11030;
	localparam int LIMIT = 99000;
	logic ref_clk = 1'h0;
	logic sense_clk = 1'h0;
	logic rst = 1'h1;
	logic [NUM_SENSE-1:0] sense_input = '0;
	logic scl, sda_rel, sda_line, sda_out, sda_drive_n, attn_n;
	logic [NUM_LED-1:0] led_output;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	integer seed = 32'hB4FD;
	int ones [NUM_LED];
	int k, i, j, mid;
	logic [7:0] rd, junk;
	logic ack;

	always #5 ref_clk = ~ref_clk;
	// Sense clock is free running and offset so its rising edges never line up with those of ref_clk
	initial begin
		#2;
		forever #24 sense_clk = ~sense_clk;
	end
	// Open-drain data line with pull-up
	assign sda_line = sda_rel & (sda_drive_n | sda_out);

	i2c_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

	touch_ctrl #(.FADE_STEP(FSTEP), .SLAVE_ADDR(HOST_ADDR)) DUT (
		.ref_clk(ref_clk), .rst(rst), .sense_clk(sense_clk), .sense_input(sense_input),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
		.host_attention_line_n(attn_n), .led_output(led_output));

	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Counts high cycles per LED over one full PWM period, sampled after the edge settles
	task automatic measure();
		for (int l = 0; l < NUM_LED; l++) ones[l] = 0;
		repeat (256) begin
			@(posedge ref_clk);
			#1;
			for (int l = 0; l < NUM_LED; l++) ones[l] += (led_output[l] === 1'h1);
		end
	endtask

	// A lit LED holds full duty, 255 of 256 steps; a dark one never goes high
	function automatic logic [15:0] exp_ones(input logic lit);
		return lit ? {8'h00, LED_FULL} : {8'h00, LED_DARK};
	endfunction

	task automatic expect_leds(input logic [NUM_LED-1:0] lit);
		measure();
		for (int l = 0; l < NUM_LED; l++) check(ones[l][15:0], exp_ones(lit[l]), "led duty");
	endtask

	// Two windows give one whole window after any input change, plus room for a full fade
	task automatic wait_scan();
		repeat (SCAN_WAIT) @(posedge ref_clk);
	endtask

	task automatic host_read(input logic [7:0] ptr, output logic [7:0] d);
		host.start();
		host.xfer_byte({HOST_ADDR, 1'h0}, 1'h1, junk, ack);
		check({15'h0000, ack}, 16'h0000, "address ack");
		host.xfer_byte(ptr, 1'h1, junk, ack);
		check({15'h0000, ack}, 16'h0000, "pointer ack");
		host.start();
		host.xfer_byte({HOST_ADDR, 1'h1}, 1'h1, junk, ack);
		check({15'h0000, ack}, 16'h0000, "read address ack");
		host.xfer_byte(8'hFF, 1'h1, d, ack);
		host.stop();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Hang guard: the whole sequence needs about 89000 cycles, just under LIMIT
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			results();
		end
	end

	initial begin
		k = $unsigned($random(seed)) % NUM_BUTTON;
		i = $unsigned($random(seed)) % (SLIDER_LEN - 1);
		j = i + 1 + $unsigned($random(seed)) % (SLIDER_LEN - 1 - i);
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		#1;
		check({8'h00, led_output}, 16'h0000, "leds after reset");
		check({15'h0000, attn_n}, 16'h0001, "attention after reset");
		check({15'h0000, sda_drive_n}, 16'h0001, "sda after reset");
		check({15'h0000, sda_out}, 16'h0000, "sda data level");
		// A slow master addressing some other device gets no acknowledge
		host.q = 130;
		host.start();
		host.xfer_byte({HOST_ADDR ^ 7'h05, 1'h0}, 1'h1, junk, ack);
		host.stop();
		check({15'h0000, ack}, 16'h0001, "foreign address ack");
		host.q = 65;
		// Button touch lights its own LED alone, with no bus traffic at all
		@(posedge ref_clk);
		sense_input[k] <= 1'h1;
		wait_scan();
		check({15'h0000, attn_n}, 16'h0000, "attention on touch");
		expect_leds(NUM_LED'(1) << k);
		host_read(REG_BUTTON, rd);
		check({8'h00, rd}, 16'h0001 << k, "button status");
		check({15'h0000, attn_n}, 16'h0000 + 16'h0001, "attention after read");
		host_read(REG_SLIDER, rd);
		check({8'h00, rd}, 16'h0000, "slider status");
		// Release fades out over several PWM periods rather than at once
		@(posedge ref_clk);
		sense_input[k] <= 1'h0;
		mid = 0;
		for (int n = 0; n < 60; n++) begin
			measure();
			if (ones[k] > 0 && ones[k] < 255) mid++;
			if (ones[k] == 0) break;
		end
		check(ones[k][15:0], 16'h0000, "led dark after release");
		check({15'h0000, mid >= 2}, 16'h0001, "gradual fade");
		check({15'h0000, attn_n}, 16'h0000, "attention on release");
		// Slider: two sensors tie so the lower one wins, then the finger moves up and back
		@(posedge ref_clk);
		sense_input[SLIDER_BASE + i] <= 1'h1;
		sense_input[SLIDER_BASE + j] <= 1'h1;
		wait_scan();
		@(posedge ref_clk);
		sense_input[SLIDER_BASE + i] <= 1'h0;
		wait_scan();
		expect_leds(8'h40);
		@(posedge ref_clk);
		sense_input[SLIDER_BASE + i] <= 1'h1;
		wait_scan();
		expect_leds(8'h80);
		// Ties go to the lower sensor, so the finger now sits on segment i
		host_read(REG_POSITION, rd);
		check({8'h00, rd}, 16'(i), "slider position");
		results();
	end
endmodule

// ==== verilog/charge_to_count_frontend.sv ====
// One sensing channel: turns a comparator level into a tick count per window.
// Runs on the sense clock; window_end comes from the same domain.
`timescale 1ns/10ps
module charge_to_count_frontend
	import touch_pkg::*;
#(
	parameter int TW = TICK_W
) (
	input wire logic sense_clk,
	input wire logic sense_rst,
	input wire logic sense_pin,
	input wire logic window_end,
	output logic [TW-1:0] count_hold
);
	logic pin_s1_r;
	logic pin_s2_r;
	logic [TW-1:0] cnt_r;
	wire logic cnt_full = &cnt_r;

	////////////////////////////////////////////////////////////////////////
	// Pin arrives from the analog side, so two flops before any use
	always_ff @(posedge sense_clk) begin
		pin_s1_r <= sense_pin;
		pin_s2_r <= pin_s1_r;
	end

	// More charge keeps the comparator high longer, so more ticks
	always_ff @(posedge sense_clk) begin
		if (sense_rst) begin
			cnt_r <= '0;
			count_hold <= '0;
		end else if (window_end) begin
			count_hold <= cnt_r; // see R09
			cnt_r <= '0;
		end else if (pin_s2_r && !cnt_full) begin
			cnt_r <= cnt_r + 1'b1; // Saturates rather than wrapping, see R09
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sense_clk); endclocking
	default disable iff (sense_rst);

	AST_TICK_MONO: assert property (!window_end |=> cnt_r >= $past(cnt_r)) // see R09
		else $error("tick count fell inside a window");
endmodule

// ==== verilog/led_fader.sv ====
// One LED channel: logarithmic fade engine and its own PWM generator.
// step_tick is a one-cycle strobe shared by all channels on ref_clk.
`timescale 1ns/10ps
module led_fader
	import touch_pkg::*;
#(
	parameter int PW = PWM_W,
	parameter logic [PWM_W-1:0] FULL = LED_FULL
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic lit,
	input wire logic step_tick,
	output logic led
);
	logic [PW-1:0] duty_r;
	logic [PW-1:0] duty_nxt;
	logic [PW-1:0] pwm_r;

	////////////////////////////////////////////////////////////////////////
	// Proportional steps give an exponential ramp, which the eye reads as smooth
	wire logic [PW:0] grow = {1'b0, duty_r} + ({1'b0, duty_r} >> FADE_SHIFT) + 1'b1;
	wire logic [PW-1:0] grow_sat = (grow >= {1'b0, FULL}) ? FULL : grow[PW-1:0];
	wire logic [PW-1:0] decay = (duty_r == '0) ? '0 :
		duty_r - (duty_r >> FADE_SHIFT) - 1'b1;
	assign duty_nxt = !step_tick ? duty_r : (lit ? grow_sat : decay); // see R04 see R13 see R14

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			duty_r <= '0;
		end else begin
			duty_r <= duty_nxt;
		end
	end

	// Each channel owns its 256-step modulator so phases never interact
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwm_r <= '0;
			led <= 1'b0;
		end else begin
			pwm_r <= pwm_r + 1'b1;
			led <= (pwm_r < duty_r); // see R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_FADE_IN: assert property (lit && step_tick && duty_r < FULL |=> duty_r > $past(duty_r)) // see R13
		else $error("fade-in did not brighten");
	AST_FULL_HOLD: assert property (lit && duty_r == FULL |=> duty_r == FULL) // see R14
		else $error("held level left full intensity");
	AST_FADE_OUT: assert property (!lit && step_tick && duty_r != '0 |=> duty_r < $past(duty_r)) // see R04
		else $error("fade-out did not dim");
	AST_PWM_OUT: assert property (##1 led == ($past(pwm_r) < $past(duty_r))) // see R12
		else $error("PWM output disagrees with duty");
endmodule

// ==== verilog/touch_ctrl.sv ====
// Touch controller top: sensing, touch decisions, slider, LED lighting, host link.
// Assumes sense_clk is free running; the host link is oversampled on ref_clk.
//
// Contract
// R01: Reset gives six buttons, a six-sensor slider and eight log-fading LEDs.
// R02: That default works at power-up with no programming and no host.
// R03: Touch on sense input zero switches on LED output zero automatically.
// R04: Release of sense input zero dims LED zero to off logarithmically.
// R05: Sense inputs one to five each drive their own LED showing touch state.
// R06: Inputs six to eleven form a slider; movement lights LED six or seven.
// R07: Touch detection and fading run with no host bus traffic.
// R08: Host link is a standard/fast mode slave; master stays at or below 400 kHz.
// R09: Front end turns sensor charge into a tick count rising with charge.
// R10: Tick counts become touched and released states for the host.
// R11: Interrupt line asserts whenever new touch information is available.
// R12: Each of eight LEDs has its own 256-step PWM generator.
// R13: With touch lighting on, a touch starts its LED fade-in unaided.
// R14: Touched LED ramps to full intensity and holds until release.
`timescale 1ns/10ps
module touch_ctrl
	import touch_pkg::*;
#(
	parameter int FADE_STEP = FADE_STEP_CYC,
	parameter logic [6:0] SLAVE_ADDR = HOST_ADDR
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sense_clk,
	input wire logic [NUM_SENSE-1:0] sense_input,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_drive_n,
	output logic host_attention_line_n,
	output logic [NUM_LED-1:0] led_output
);
	////////////////////////////////////////////////////////////////////////
	// Sense clock domain
	logic srst_s1_r;
	logic srst_r;
	logic [TICK_W-1:0] win_r;
	logic scan_tog_r;
	logic [TICK_W-1:0] hold [NUM_SENSE];
	wire logic window_end = (win_r == WINDOW_LAST);

	// Reset is a level from ref_clk, carried over by two flops
	always_ff @(posedge sense_clk) begin
		srst_s1_r <= rst;
		srst_r <= srst_s1_r;
	end

	// Free-running window; no host needed to start scanning, see R02 see R07
	always_ff @(posedge sense_clk) begin
		if (srst_r) begin
			win_r <= '0;
			scan_tog_r <= 1'b0;
		end else begin
			win_r <= win_r + 1'b1;
			scan_tog_r <= scan_tog_r ^ window_end; // Event crosses as a toggle
		end
	end

	for (genvar i = 0; i < NUM_SENSE; i++) begin : g_sense
		charge_to_count_frontend #(.TW(TICK_W)) u_fe (
			.sense_clk(sense_clk),
			.sense_rst(srst_r),
			.sense_pin(sense_input[i]),
			.window_end(window_end),
			.count_hold(hold[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Crossing: held counts stay still for a whole window after the toggle,
	// far longer than the three ref_clk cycles the toggle takes to arrive
	logic tog_s1_r;
	logic tog_s2_r;
	logic tog_d_r;
	logic scan_new_r;
	logic scan_upd_r;
	logic [TICK_W-1:0] counts_r [NUM_SENSE];
	wire logic scan_seen = tog_s2_r ^ tog_d_r;

	always_ff @(posedge ref_clk) begin
		tog_s1_r <= scan_tog_r;
		tog_s2_r <= tog_s1_r;
		tog_d_r <= tog_s2_r;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scan_new_r <= 1'b0;
			scan_upd_r <= 1'b0;
		end else begin
			scan_new_r <= scan_seen;
			scan_upd_r <= scan_new_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < NUM_SENSE; i++) begin
			if (rst) begin
				counts_r[i] <= '0;
			end else if (scan_seen) begin
				counts_r[i] <= hold[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Touch decisions with hysteresis so transients do not chatter
	logic [NUM_SENSE-1:0] touched_r;
	logic [NUM_SENSE-1:0] touch_hit;
	logic [NUM_SENSE-1:0] touch_lost;

	for (genvar i = 0; i < NUM_SENSE; i++) begin : g_hit
		assign touch_hit[i] = (counts_r[i] >= HIT_LEVEL);
		assign touch_lost[i] = (counts_r[i] < OFF_LEVEL);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			touched_r <= '0;
		end else if (scan_new_r) begin
			touched_r <= (touched_r | touch_hit) & ~touch_lost; // see R10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slider: the strongest touched segment gives the finger position
	logic [2:0] best_idx;
	logic [TICK_W-1:0] best_val;
	logic [2:0] pos_r;
	logic slide_was_r;
	logic dir_up_r;
	logic dir_dn_r;
	wire logic slide_any = |touched_r[SLIDER_BASE +: SLIDER_LEN];

	always_comb begin
		best_idx = 3'h0;
		best_val = '0;
		for (int k = 0; k < SLIDER_LEN; k++) begin
			if (touched_r[SLIDER_BASE + k] && counts_r[SLIDER_BASE + k] > best_val) begin
				best_val = counts_r[SLIDER_BASE + k];
				best_idx = 3'(k);
			end
		end
	end

	// Direction LEDs hold until the finger leaves or reverses, then fade out
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pos_r <= 3'h0;
			slide_was_r <= 1'b0;
			dir_up_r <= 1'b0;
			dir_dn_r <= 1'b0;
		end else if (scan_upd_r) begin
			pos_r <= best_idx;
			slide_was_r <= slide_any;
			if (!slide_any) begin
				dir_up_r <= 1'b0;
				dir_dn_r <= 1'b0;
			end else if (slide_was_r && best_idx > pos_r) begin
				dir_up_r <= 1'b1; // see R06
				dir_dn_r <= 1'b0;
			end else if (slide_was_r && best_idx < pos_r) begin
				dir_up_r <= 1'b0;
				dir_dn_r <= 1'b1; // see R06
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lighting: buttons map one-to-one, slider drives the last two LEDs
	logic [31:0] step_cnt_r;
	logic step_tick_r;
	wire logic [NUM_LED-1:0] led_lit = {dir_dn_r, dir_up_r, touched_r[NUM_BUTTON-1:0]}; // see R01 see R03 see R05

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			step_cnt_r <= '0;
			step_tick_r <= 1'b0;
		end else begin
			step_tick_r <= (step_cnt_r == 32'(FADE_STEP - 1));
			step_cnt_r <= (step_cnt_r == 32'(FADE_STEP - 1)) ? '0 : step_cnt_r + 1'b1;
		end
	end

	for (genvar i = 0; i < NUM_LED; i++) begin : g_led
		led_fader #(.PW(PWM_W), .FULL(LED_FULL)) u_fader ( // see R12 see R13
			.ref_clk(ref_clk),
			.rst(rst),
			.lit(led_lit[i]),
			.step_tick(step_tick_r),
			.led(led_output[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Host link pins, two flops then one more for edge detection
	logic scl_s1_r;
	logic scl_s2_r;
	logic scl_d_r;
	logic sda_s1_r;
	logic sda_s2_r;
	logic sda_d_r;

	always_ff @(posedge ref_clk) begin
		scl_s1_r <= scl_in;
		scl_s2_r <= scl_s1_r;
		scl_d_r <= scl_s2_r;
		sda_s1_r <= sda_in;
		sda_s2_r <= sda_s1_r;
		sda_d_r <= sda_s2_r;
	end

	wire logic scl_rise = scl_s2_r && !scl_d_r;
	wire logic scl_fall = !scl_s2_r && scl_d_r;
	wire logic bus_start = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
	wire logic bus_stop = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

	link_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [7:0] ptr_r;
	logic rw_r;
	logic first_wr_r;
	logic rd_clear_r;

	// Read data by pointer; unmapped offsets read as zero
	wire logic [7:0] rd_byte = (ptr_r == REG_BUTTON) ? {2'h0, touched_r[NUM_BUTTON-1:0]} :
		(ptr_r == REG_SLIDER) ? {2'h0, touched_r[SLIDER_BASE +: SLIDER_LEN]} :
		(ptr_r == REG_POSITION) ? {5'h00, pos_r} : 8'h00;
	wire logic byte_done = (bit_cnt_r == BITS_PER_BYTE);
	wire logic addr_hit = (shift_r[7:1] == SLAVE_ADDR);

	// Open-drain slave: only ever pulls low, a released line reads high, see R08
	always_ff @(posedge ref_clk) begin
		if (rst || bus_stop) begin
			state_r <= LNK_IDLE;
			bit_cnt_r <= 4'h0;
			sda_drive_n <= 1'b1;
			rd_clear_r <= 1'b0;
		end else if (bus_start) begin
			state_r <= LNK_ADDR;
			bit_cnt_r <= 4'h0;
			sda_drive_n <= 1'b1;
			rd_clear_r <= 1'b0;
		end else begin
			rd_clear_r <= 1'b0;
			case (state_r)
				LNK_ADDR, LNK_WRITE: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_s2_r};
						bit_cnt_r <= bit_cnt_r + 1'b1;
					end else if (scl_fall && byte_done && state_r == LNK_ADDR) begin
						sda_drive_n <= !addr_hit; // see R08
						rw_r <= shift_r[0];
						state_r <= addr_hit ? LNK_ADDR_ACK : LNK_IDLE;
					end else if (scl_fall && byte_done) begin
						sda_drive_n <= 1'b0;
						state_r <= LNK_WR_ACK;
						first_wr_r <= 1'b0;
						if (first_wr_r) begin
							ptr_r <= shift_r; // First written byte picks the register
						end
					end
				end
				LNK_WR_ACK: begin
					if (scl_fall) begin
						sda_drive_n <= 1'b1;
						bit_cnt_r <= 4'h0;
						state_r <= LNK_WRITE;
					end
				end
				LNK_ADDR_ACK, LNK_RD_ACK: begin
					if (scl_rise && state_r == LNK_RD_ACK) begin
						if (sda_s2_r) begin
							state_r <= LNK_IDLE; // Master refused more data
						end else begin
							ptr_r <= ptr_r + 1'b1;
						end
					end else if (scl_fall && rw_r) begin
						sda_drive_n <= rd_byte[7];
						tx_r <= {rd_byte[6:0], 1'b1};
						bit_cnt_r <= 4'h1;
						rd_clear_r <= (ptr_r == REG_BUTTON);
						state_r <= LNK_READ;
					end else if (scl_fall) begin
						sda_drive_n <= 1'b1;
						bit_cnt_r <= 4'h0;
						first_wr_r <= 1'b1;
						state_r <= LNK_WRITE;
					end
				end
				LNK_READ: begin
					if (scl_fall && byte_done) begin
						sda_drive_n <= 1'b1;
						state_r <= LNK_RD_ACK;
					end else if (scl_fall) begin
						sda_drive_n <= tx_r[7];
						tx_r <= {tx_r[6:0], 1'b1};
						bit_cnt_r <= bit_cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= LNK_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Attention line: a new touch state wins over a read in the same cycle
	logic [NUM_SENSE-1:0] prev_touch_r;
	wire logic touch_event = scan_upd_r && (touched_r != prev_touch_r);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_touch_r <= '0;
			host_attention_line_n <= 1'b1;
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			if (scan_upd_r) begin
				prev_touch_r <= touched_r;
			end
			if (touch_event) begin
				host_attention_line_n <= 1'b0; // see R11
			end else if (rd_clear_r) begin
				host_attention_line_n <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_TOUCH_SET: assert property (scan_new_r && counts_r[0] >= HIT_LEVEL |=> touched_r[0]) // see R10
		else $error("strong count did not mark a touch");
	AST_TOUCH_CLEAR: assert property (scan_new_r && counts_r[1] < OFF_LEVEL |=> !touched_r[1]) // see R10
		else $error("weak count did not mark a release");
	AST_INT_EVENT: assert property (touch_event |=> !host_attention_line_n) // see R11
		else $error("attention line missed a touch change");
	AST_ADDR_ACK: assert property (state_r == LNK_ADDR && scl_fall && byte_done && addr_hit
		|=> !sda_drive_n && state_r == LNK_ADDR_ACK) // see R08
		else $error("own address not acknowledged");
	AST_SLIDE_UP: assert property (scan_upd_r && slide_any && slide_was_r && best_idx > pos_r
		|=> dir_up_r && !dir_dn_r) // see R06
		else $error("upward slide did not light its LED");
	AST_SCAN_PIPE: assert property (scan_seen |=> scan_new_r ##1 scan_upd_r) // see R07
		else $error("scan result did not flow on its own");

	COV_BUTTON_TOUCH: cover property (scan_new_r && touch_hit[0] ##1 touched_r[0]);
	COV_SLIDE_DOWN: cover property (scan_upd_r && slide_any && slide_was_r && best_idx < pos_r);
	COV_HOST_READ: cover property (state_r == LNK_ADDR_ACK && rw_r ##[1:400] rd_clear_r);
endmodule

// ==== verilog/touch_pkg.sv ====
// Shared constants and types for the touch-to-LED controller.
// Assumes a 100 MHz system clock; the sense clock rate only sets the tick window.
package touch_pkg;
	// Channel counts and widths
	localparam int NUM_SENSE = 12;
	localparam int NUM_BUTTON = 6;
	localparam int NUM_LED = 8;
	localparam int SLIDER_BASE = 6;
	localparam int SLIDER_LEN = 6;
	localparam int TICK_W = 10;
	localparam int PWM_W = 8;
	localparam int FADE_SHIFT = 3;

	// Detection levels in ticks
	localparam logic [9:0] TOUCH_THR = 10'h190;
	localparam logic [9:0] TOUCH_HYST = 10'h028;
	localparam logic [9:0] HIT_LEVEL = TOUCH_THR + TOUCH_HYST;
	localparam logic [9:0] OFF_LEVEL = TOUCH_THR - TOUCH_HYST;
	localparam logic [9:0] WINDOW_LAST = 10'h3FF;

	// LED intensity
	localparam logic [7:0] LED_FULL = 8'hFF;
	localparam logic [7:0] LED_DARK = 8'h00;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int FADE_STEP_NS = 4000000;
	localparam int FADE_STEP_CYC = FADE_STEP_NS / CLK_PERIOD_NS;

	// Host link
	localparam logic [6:0] HOST_ADDR = 7'h2B;
	localparam logic [7:0] REG_BUTTON = 8'h00;
	localparam logic [7:0] REG_SLIDER = 8'h01;
	localparam logic [7:0] REG_POSITION = 8'h02;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		LNK_IDLE = 3'b000,
		LNK_ADDR = 3'b001,
		LNK_ADDR_ACK = 3'b010,
		LNK_WRITE = 3'b011,
		LNK_WR_ACK = 3'b100,
		LNK_READ = 3'b101,
		LNK_RD_ACK = 3'b110
	} link_state_t;
endpackage
